// ===== shared/dcc_pkg.sv
// shared constants and carrier types of the dma channel controller
package dcc_pkg;
  localparam int CH_NUM = 8;
  localparam int CH_W = 3;
  localparam int ADDR_W = 24;
  localparam int CNT_W = 24;
  localparam int HOLD_W = 32;
  localparam int DATA_W = 16;
  localparam logic [CH_W-1:0] ACK_IDLE = 3'h4;
  localparam logic [2:0] SZ_BYTE = 3'h1;
  localparam logic [2:0] SZ_WORD = 3'h2;
  localparam logic [2:0] HOLD_EMPTY = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_RST = 24'h000000;
  localparam logic [CNT_W-1:0] CNT_RST = 24'h000000;
  localparam logic [HOLD_W-1:0] HOLD_RST = 32'h00000000;

  typedef enum logic [1:0] {DCC_STEP_INC, DCC_STEP_DEC, DCC_STEP_FIX} dcc_step_type;

  typedef struct packed {
    logic tgt_to_req;
    logic autoinit;
    logic req_io;
    logic tgt_io;
    logic req_word;
    logic tgt_word;
    dcc_step_type req_step;
    dcc_step_type tgt_step;
  } dcc_mode_type;

  typedef struct packed {
    logic [ADDR_W-1:0] req_addr;
    logic [ADDR_W-1:0] tgt_addr;
    logic [CNT_W-1:0] count;
    dcc_mode_type mode;
  } dcc_cfg_type;

  typedef struct packed {
    logic [ADDR_W-1:0] req_addr;
    logic [ADDR_W-1:0] tgt_addr;
    logic [CNT_W-1:0] count;
    logic tc;
    logic armed;
  } dcc_stat_type;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic write;
    logic word;
    logic io;
    logic [1:0] ben;
    logic [DATA_W-1:0] wdata;
  } dcc_bus_type;
endpackage

// ===== logic/dcc_sync.sv
// two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module dcc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // pins and synchronised levels
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] meta_reg;

  // only the second stage is visible to any logic
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      meta_reg <= RST_VAL;
      sync_o <= RST_VAL;
    end else begin
      meta_reg <= async_i;
      sync_o <= meta_reg;
    end
  end
endmodule

// ===== logic/dcc_prio_arb.sv
// fixed priority picker, lowest channel number wins
`timescale 1ns/1ps
module dcc_prio_arb #(
  parameter int N = 8,
  parameter int IW = 3
) (
  // pending channels
  input wire logic [N-1:0] pend_i,
  // winner
  output logic any_o,
  output logic [IW-1:0] win_o
);
  if (N > (1 << IW)) begin : g_bad_width
    $error("dcc_prio_arb: index too narrow");
  end

  always_comb begin
    any_o = |pend_i;
    win_o = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (pend_i[i]) begin
        win_o = IW'(i);
      end
    end
  end
endmodule

// ===== logic/dcc_core.sv
// dma channel controller core: channel state, yield handshake, transfer engine
//
// Contract
// - base address and count never changed by hardware
// - per-side address increment, decrement or fixed
// - count drops one per byte moved
// - underflow flags terminal count, ends or restarts
// - private 32-bit holding register per channel
// - unpacking: surplus held byte is discarded
// - packing: unfilled final byte is undefined
// - stay bus slave until service request
// - accept programming any time while slave
// - service request raises bus yield request
// - master only after yield grant seen
// - pick highest priority when mastership obtained
// - keep bus until grant removed or done; code also releases when the channel's request drops
// - transfer uses serviced channel's own registers
// - completion drops yield request, back to slave
// - further pending requests re-raise yield request
// - eight requests, encoded ack, yield pair, eop
// - only requester starts or ends processes; code also starts one on a software request (sw_req_i)
// - per-channel direction, memory or io sides
// - each bus cycle moves one byte or word
// - ack shows idle code outside requester access
// - eop driven on last requester cycle, input terminates
`timescale 1ns/1ps
module dcc_core #(
  parameter int CH_NUM = dcc_pkg::CH_NUM
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // peripheral handshake
  input wire logic [dcc_pkg::CH_NUM-1:0] channel_service_request_i,
  output logic [dcc_pkg::CH_W-1:0] encoded_channel_ack_o,
  input wire logic end_of_process_n_i,
  output logic end_of_process_n_o,
  output logic end_of_process_oe_n_o,
  // host yield handshake
  output logic bus_yield_req_o,
  input wire logic bus_yield_grant_i,
  // host programming and status
  input wire logic [dcc_pkg::CH_NUM-1:0] sw_req_i,
  input wire logic prog_we_i,
  input wire logic [dcc_pkg::CH_W-1:0] prog_ch_i,
  input wire dcc_pkg::dcc_cfg_type prog_cfg_i,
  output logic prog_ready_o,
  input wire logic [dcc_pkg::CH_W-1:0] rd_ch_i,
  output dcc_pkg::dcc_stat_type rd_stat_o,
  // master bus cycles
  output logic bus_valid_o,
  output dcc_pkg::dcc_bus_type bus_o,
  input wire logic bus_done_i,
  input wire logic [dcc_pkg::DATA_W-1:0] bus_rdata_i
);
  import dcc_pkg::*;

  if (CH_NUM != dcc_pkg::CH_NUM) begin : g_bad_ch
    $error("dcc_core: channel count must match the encoded ack width");
  end

  typedef enum logic [2:0] {
    ST_SLAVE, ST_YIELD_REQ, ST_PICK, ST_ISSUE, ST_READ, ST_WRITE, ST_RELEASE
  } dcc_state_type;

  function automatic logic [ADDR_W-1:0] dcc_step_addr(input logic [ADDR_W-1:0] a,
                                                      input dcc_step_type s,
                                                      input logic word);
    logic [ADDR_W-1:0] d;
    d = word ? ADDR_W'(2) : ADDR_W'(1);
    case (s)
      DCC_STEP_INC: dcc_step_addr = a + d;
      DCC_STEP_DEC: dcc_step_addr = a - d;
      default: dcc_step_addr = a;
    endcase
  endfunction

  dcc_state_type state_reg;
  logic [CH_W-1:0] act_ch_reg;
  logic [ADDR_W-1:0] base_req_reg [CH_NUM];
  logic [ADDR_W-1:0] base_tgt_reg [CH_NUM];
  logic [CNT_W-1:0] base_cnt_reg [CH_NUM];
  logic [ADDR_W-1:0] cur_req_reg [CH_NUM];
  logic [ADDR_W-1:0] cur_tgt_reg [CH_NUM];
  logic [CNT_W-1:0] cur_cnt_reg [CH_NUM];
  dcc_mode_type mode_reg [CH_NUM];
  logic [HOLD_W-1:0] hold_reg [CH_NUM];
  logic [2:0] hold_cnt_reg [CH_NUM];
  logic [CH_NUM-1:0] armed_reg;
  logic [CH_NUM-1:0] tc_reg;
  logic [CH_NUM-1:0] sw_pend_reg;
  logic eop_drive_reg;
  logic [1:0] eop_hist_reg;
  logic [CH_NUM-1:0] hw_req_sync;
  logic grant_sync;
  logic eop_n_sync;
  logic [CH_NUM-1:0] pend;
  logic any_pend;
  logic [CH_W-1:0] win_ch;
  logic prog_acc;
  dcc_mode_type m;
  logic [2:0] hc;
  logic [CNT_W:0] remain;
  logic src_is_req;
  logic src_word;
  logic dst_word;
  logic [2:0] s_sz;
  logic [2:0] d_sz;
  logic need_fetch;
  logic do_read;
  logic last_write;
  logic last_fetch;
  logic [2:0] consumed;
  logic ext_eop;
  logic rd_done;
  logic wr_done;
  logic term;
  logic [7:0] rd_byte;
  logic [DATA_W-1:0] rd_val;
  logic [ADDR_W-1:0] src_addr;

  // eight requests, yield grant and eop pass the synchroniser
  dcc_sync #(
    .W(CH_NUM + 2),
    .RST_VAL({{CH_NUM{1'b0}}, 1'b0, 1'b1})
  ) u_sync (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .async_i({channel_service_request_i, bus_yield_grant_i, end_of_process_n_i}),
    .sync_o({hw_req_sync, grant_sync, eop_n_sync})
  );

  assign pend = armed_reg & (hw_req_sync | sw_pend_reg);

  dcc_prio_arb #(
    .N(CH_NUM),
    .IW(CH_W)
  ) u_arb (
    .pend_i(pend),
    .any_o(any_pend),
    .win_o(win_ch)
  );

  always_comb begin
    m = mode_reg[act_ch_reg];
    hc = hold_cnt_reg[act_ch_reg];
    remain = {1'b0, cur_cnt_reg[act_ch_reg]} + (CNT_W+1)'(1);
    src_is_req = ~m.tgt_to_req;
    src_word = src_is_req ? m.req_word : m.tgt_word;
    dst_word = src_is_req ? m.tgt_word : m.req_word;
    s_sz = src_word ? SZ_WORD : SZ_BYTE;
    d_sz = dst_word ? SZ_WORD : SZ_BYTE;
    need_fetch = remain > (CNT_W+1)'(hc);
    do_read = need_fetch && (hc < d_sz);
    last_write = remain <= (CNT_W+1)'(d_sz);
    last_fetch = (remain - (CNT_W+1)'(hc)) <= (CNT_W+1)'(s_sz);
    consumed = last_write ? remain[2:0] : d_sz;
    src_addr = src_is_req ? cur_req_reg[act_ch_reg] : cur_tgt_reg[act_ch_reg];
    rd_byte = bus_o.addr[0] ? bus_rdata_i[15:8] : bus_rdata_i[7:0];
    rd_val = bus_o.word ? bus_rdata_i : {8'h00, rd_byte};
  end

  // own eop not taken as input
  assign ext_eop = ~eop_n_sync & ~eop_drive_reg & ~(|eop_hist_reg);
  assign rd_done = (state_reg == ST_READ) && bus_done_i;
  assign wr_done = (state_reg == ST_WRITE) && bus_done_i;
  assign term = (wr_done && last_write) || ((rd_done || wr_done) && ext_eop);
  assign prog_ready_o = (state_reg == ST_SLAVE);
  assign prog_acc = prog_we_i && prog_ready_o;
  assign bus_valid_o = (state_reg == ST_READ) || (state_reg == ST_WRITE);
  // request raised from yield wait, low in release and slave
  assign bus_yield_req_o = (state_reg != ST_SLAVE) && (state_reg != ST_RELEASE);
  assign end_of_process_n_o = 1'b0;
  assign end_of_process_oe_n_o = ~eop_drive_reg;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      state_reg <= ST_SLAVE;
      act_ch_reg <= '0;
    end else begin
      case (state_reg)
        ST_SLAVE: begin
          if (any_pend) begin
            state_reg <= ST_YIELD_REQ;
          end
        end
        ST_YIELD_REQ: begin
          if (grant_sync) begin
            state_reg <= ST_PICK;
          end
        end
        ST_PICK: begin
          if (any_pend) begin
            act_ch_reg <= win_ch;
            state_reg <= ST_ISSUE;
          end else begin
            state_reg <= ST_RELEASE;
          end
        end
        ST_ISSUE: state_reg <= do_read ? ST_READ : ST_WRITE;
        ST_READ, ST_WRITE: begin
          // hold until done, then release on terminal count, lost grant or dropped request
          if (bus_done_i) begin
            if (term || !grant_sync || !pend[act_ch_reg]) begin
              state_reg <= ST_RELEASE;
            end else begin
              state_reg <= ST_ISSUE;
            end
          end
        end
        ST_RELEASE: state_reg <= ST_SLAVE;
        default: state_reg <= ST_SLAVE;
      endcase
    end
  end

  // bus cycle setup, loaded once per cycle so outputs stand until done
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      bus_o <= '0;
      encoded_channel_ack_o <= ACK_IDLE;
      eop_drive_reg <= 1'b0;
    end else if (state_reg == ST_ISSUE) begin
      bus_o.write <= ~do_read;
      bus_o.word <= do_read ? src_word : dst_word;
      if (do_read == src_is_req) begin
        bus_o.addr <= cur_req_reg[act_ch_reg];
        bus_o.io <= m.req_io;
        encoded_channel_ack_o <= act_ch_reg;
      end else begin
        bus_o.addr <= cur_tgt_reg[act_ch_reg];
        bus_o.io <= m.tgt_io;
        encoded_channel_ack_o <= ACK_IDLE;
      end
      if ((do_read ? src_word : dst_word)) begin
        bus_o.ben <= 2'h3;
      end else if ((do_read ? src_addr[0]
                   : (src_is_req ? cur_tgt_reg[act_ch_reg][0] : cur_req_reg[act_ch_reg][0]))) begin
        bus_o.ben <= 2'h2;
      end else begin
        bus_o.ben <= 2'h1;
      end
      // upper byte of short final word is stale hold data
      bus_o.wdata <= dst_word ? hold_reg[act_ch_reg][15:0]
                              : {hold_reg[act_ch_reg][7:0], hold_reg[act_ch_reg][7:0]};
      eop_drive_reg <= do_read ? (src_is_req && last_fetch) : (!src_is_req && last_write);
    end else if (!bus_valid_o || bus_done_i) begin
      // drop ack and eop as the cycle ends, so neither lingers into release or the next issue
      encoded_channel_ack_o <= ACK_IDLE;
      eop_drive_reg <= 1'b0;
    end
  end

  // our own eop echo comes back through the synchroniser two cycles late
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      eop_hist_reg <= 2'h0;
    end else begin
      eop_hist_reg <= {eop_hist_reg[0], eop_drive_reg};
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < CH_NUM; i++) begin
        base_req_reg[i] <= ADDR_RST;
        base_tgt_reg[i] <= ADDR_RST;
        base_cnt_reg[i] <= CNT_RST;
        mode_reg[i] <= '0;
      end
    end else if (prog_acc) begin
      base_req_reg[prog_ch_i] <= prog_cfg_i.req_addr;
      base_tgt_reg[prog_ch_i] <= prog_cfg_i.tgt_addr;
      base_cnt_reg[prog_ch_i] <= prog_cfg_i.count;
      mode_reg[prog_ch_i] <= prog_cfg_i.mode;
    end
  end

  // current addresses
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < CH_NUM; i++) begin
        cur_req_reg[i] <= ADDR_RST;
        cur_tgt_reg[i] <= ADDR_RST;
      end
    end else if (prog_acc) begin
      cur_req_reg[prog_ch_i] <= prog_cfg_i.req_addr;
      cur_tgt_reg[prog_ch_i] <= prog_cfg_i.tgt_addr;
    end else if (term && m.autoinit) begin
      cur_req_reg[act_ch_reg] <= base_req_reg[act_ch_reg];
      cur_tgt_reg[act_ch_reg] <= base_tgt_reg[act_ch_reg];
    end else if (rd_done || wr_done) begin
      if (rd_done == src_is_req) begin
        cur_req_reg[act_ch_reg] <= dcc_step_addr(cur_req_reg[act_ch_reg], m.req_step,
                                                 m.req_word);
      end else begin
        cur_tgt_reg[act_ch_reg] <= dcc_step_addr(cur_tgt_reg[act_ch_reg], m.tgt_step,
                                                 m.tgt_word);
      end
    end
  end

  // current byte count
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < CH_NUM; i++) begin
        cur_cnt_reg[i] <= CNT_RST;
      end
    end else if (prog_acc) begin
      cur_cnt_reg[prog_ch_i] <= prog_cfg_i.count;
    end else if (term && m.autoinit) begin
      cur_cnt_reg[act_ch_reg] <= base_cnt_reg[act_ch_reg];
    end else if (wr_done) begin
      cur_cnt_reg[act_ch_reg] <= cur_cnt_reg[act_ch_reg] - CNT_W'(consumed);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < CH_NUM; i++) begin
        hold_reg[i] <= HOLD_RST;
        hold_cnt_reg[i] <= HOLD_EMPTY;
      end
    end else if (prog_acc) begin
      hold_cnt_reg[prog_ch_i] <= HOLD_EMPTY;
    end else if (term) begin
      hold_cnt_reg[act_ch_reg] <= HOLD_EMPTY;
    end else if (rd_done) begin
      hold_reg[act_ch_reg] <= hold_reg[act_ch_reg] | (HOLD_W'(rd_val) << (8 * hc));
      hold_cnt_reg[act_ch_reg] <= hc + s_sz;
    end else if (wr_done) begin
      hold_reg[act_ch_reg] <= hold_reg[act_ch_reg] >> (8 * consumed);
      hold_cnt_reg[act_ch_reg] <= hc - consumed;
    end
  end

  // channel flags; software request set wins over the terminal count clear in the same cycle
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      armed_reg <= '0;
      tc_reg <= '0;
      sw_pend_reg <= '0;
    end else begin
      for (int i = 0; i < CH_NUM; i++) begin
        if (prog_acc && (prog_ch_i == CH_W'(i))) begin
          armed_reg[i] <= 1'b1;
          tc_reg[i] <= 1'b0;
        end else if (term && (act_ch_reg == CH_W'(i))) begin
          armed_reg[i] <= m.autoinit;
          tc_reg[i] <= 1'b1;
        end
        if (sw_req_i[i]) begin
          sw_pend_reg[i] <= 1'b1;
        end else if (term && (act_ch_reg == CH_W'(i))) begin
          sw_pend_reg[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      rd_stat_o <= '0;
    end else begin
      rd_stat_o.req_addr <= cur_req_reg[rd_ch_i];
      rd_stat_o.tgt_addr <= cur_tgt_reg[rd_ch_i];
      rd_stat_o.count <= cur_cnt_reg[rd_ch_i];
      rd_stat_o.tc <= tc_reg[rd_ch_i];
      rd_stat_o.armed <= armed_reg[rd_ch_i];
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  chk_base_stable: assert property (!prog_acc |=> $stable(base_cnt_reg[0]))
    else $error("base count changed without programming");
  chk_count_step: assert property (wr_done && !term |=>
    cur_cnt_reg[$past(act_ch_reg)] == $past(cur_cnt_reg[act_ch_reg]) - CNT_W'($past(consumed)))
    else $error("byte count not reduced by bytes written");
  chk_tc_flag: assert property (wr_done && last_write |=> tc_reg[$past(act_ch_reg)])
    else $error("terminal count not flagged");
  chk_slave_stay: assert property (state_reg == ST_SLAVE && !any_pend |=>
    state_reg == ST_SLAVE && !bus_valid_o)
    else $error("left slave without request");
  chk_yield_raise: assert property (state_reg == ST_SLAVE && any_pend |=> bus_yield_req_o)
    else $error("yield request not raised");
  chk_grant_first: assert property (state_reg == ST_YIELD_REQ && !grant_sync |=>
    !bus_valid_o && state_reg == ST_YIELD_REQ)
    else $error("mastership taken without grant");
  chk_ack_idle: assert property (!bus_valid_o |-> encoded_channel_ack_o == ACK_IDLE)
    else $error("ack not idle outside access");
  chk_release_drop: assert property (bus_valid_o && bus_done_i && term |=>
    !bus_yield_req_o ##1 state_reg == ST_SLAVE)
    else $error("yield request kept after completion");
  chk_eop_drive: assert property (!end_of_process_oe_n_o |-> bus_valid_o)
    else $error("eop driven outside a bus cycle");
  chk_prog_slave: assert property (state_reg == ST_SLAVE |-> prog_ready_o)
    else $error("programming refused while slave");

  cov_terminal: cover property (wr_done && last_write);
  cov_ext_eop: cover property ((rd_done || wr_done) && ext_eop);
  cov_rerequest: cover property (state_reg == ST_RELEASE ##1 state_reg == ST_SLAVE
    ##1 state_reg == ST_YIELD_REQ);
endmodule

// ===== bench/dcc_host_model.sv
// host processor and bus target model facing the dma channel controller
`timescale 1ns/1ps
module dcc_host_model (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // response speed
  input wire logic [3:0] grant_dly_i,
  input wire logic [3:0] wait_i,
  // yield handshake
  input wire logic bus_yield_req_i,
  output logic bus_yield_grant_o,
  // target side of bus cycles
  input wire logic bus_valid_i,
  input wire dcc_pkg::dcc_bus_type bus_i,
  output logic bus_done_o,
  output logic [dcc_pkg::DATA_W-1:0] bus_rdata_o
);
  import dcc_pkg::*;
  logic [7:0] mem [256];
  logic [3:0] g_cnt;
  logic [3:0] w_cnt;
  logic [7:0] a0;
  initial begin
    bus_yield_grant_o = 1'b0;
    bus_done_o = 1'b0;
    bus_rdata_o = 16'h0000;
    g_cnt = 4'h0;
    w_cnt = 4'h0;
  end
  // bus given up only after the request, taken back once it falls
  always @(negedge ref_clk_i) begin
    if (!rst_n_i || !bus_yield_req_i) begin
      g_cnt <= 4'h0;
      bus_yield_grant_o <= 1'b0;
    end else if (g_cnt >= grant_dly_i) begin
      bus_yield_grant_o <= 1'b1;
    end else begin
      g_cnt <= g_cnt + 4'h1;
    end
  end
  // read data is not held between cycles, so stale lanes never look valid
  always @(negedge ref_clk_i) begin
    a0 = {bus_i.addr[7:1], 1'b0};
    bus_done_o <= 1'b0;
    bus_rdata_o <= ~bus_rdata_o;
    if (rst_n_i && bus_valid_i && !bus_done_o) begin
      if (w_cnt < wait_i) begin
        w_cnt <= w_cnt + 4'h1;
      end else begin
        w_cnt <= 4'h0;
        bus_done_o <= 1'b1;
        if (bus_i.write) begin
          if (bus_i.ben[0]) mem[a0] <= bus_i.wdata[7:0];
          if (bus_i.ben[1]) mem[a0 + 8'h01] <= bus_i.wdata[15:8];
        end else begin
          bus_rdata_o <= {mem[a0 + 8'h01], mem[a0]};
        end
      end
    end
  end
endmodule

// ===== bench/tb.sv
// self-checking testbench of the dma channel controller core
`timescale 1ns/1ps
module tb;
  import dcc_pkg::*;
  logic ref_clk_i, rst_n_i, prog_we_i, eop_pin_n, end_of_process_n_o, end_of_process_oe_n_o;
  logic bus_yield_req_o, bus_yield_grant_i, prog_ready_o, bus_valid_o, bus_done_i;
  logic [7:0] channel_service_request_i, sw_req_i;
  logic [2:0] encoded_channel_ack_o, prog_ch_i, rd_ch_i;
  logic [3:0] grant_dly, wait_n;
  logic [15:0] bus_rdata_i;
  dcc_cfg_type prog_cfg_i;
  dcc_stat_type rd_stat_o;
  dcc_bus_type bus_o;
  int n_mismatch, n_compared, n_rise;
  logic [2:0] l_ack[$];
  logic l_wr[$];
  logic l_eop[$];
  logic prev_req;
  dcc_core uut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .channel_service_request_i(channel_service_request_i),
    .encoded_channel_ack_o(encoded_channel_ack_o),
    .end_of_process_n_i(end_of_process_oe_n_o ? eop_pin_n : end_of_process_n_o),
    .end_of_process_n_o(end_of_process_n_o), .end_of_process_oe_n_o(end_of_process_oe_n_o),
    .bus_yield_req_o(bus_yield_req_o), .bus_yield_grant_i(bus_yield_grant_i),
    .sw_req_i(sw_req_i), .prog_we_i(prog_we_i), .prog_ch_i(prog_ch_i),
    .prog_cfg_i(prog_cfg_i), .prog_ready_o(prog_ready_o), .rd_ch_i(rd_ch_i),
    .rd_stat_o(rd_stat_o), .bus_valid_o(bus_valid_o), .bus_o(bus_o),
    .bus_done_i(bus_done_i), .bus_rdata_i(bus_rdata_i));
  dcc_host_model host (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .grant_dly_i(grant_dly),
    .wait_i(wait_n), .bus_yield_req_i(bus_yield_req_o), .bus_yield_grant_o(bus_yield_grant_i),
    .bus_valid_i(bus_valid_o), .bus_i(bus_o), .bus_done_o(bus_done_i),
    .bus_rdata_o(bus_rdata_i));
  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    prev_req <= bus_yield_req_o;
    if (rst_n_i && bus_yield_req_o && !prev_req) n_rise++;
    if (bus_valid_o && bus_done_i) begin
      l_ack.push_back(encoded_channel_ack_o);
      l_wr.push_back(bus_o.write);
      l_eop.push_back(end_of_process_oe_n_o);
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic dcc_cfg_type cf(input logic [23:0] ra, ta, n, input logic t2r, ai, tw);
    cf = '{ra, ta, n, '{t2r, ai, t2r, 1'b0, 1'b0, tw, DCC_STEP_INC,
      t2r ? DCC_STEP_INC : DCC_STEP_DEC}};
  endfunction
  task automatic prog(input logic [2:0] ch, input dcc_cfg_type c);
    @(negedge ref_clk_i);
    prog_we_i = 1'b1;
    prog_ch_i = ch;
    prog_cfg_i = c;
    @(negedge ref_clk_i);
    prog_we_i = 1'b0;
  endtask
  task automatic sw(input int ch);
    @(negedge ref_clk_i);
    sw_req_i[ch] = 1'b1;
    @(negedge ref_clk_i);
    sw_req_i = 8'h00;
  endtask
  // wait for the yield request, then for a quiet bus
  task automatic run_out();
    int q;
    q = 0;
    for (int i = 0; i < 40 && !bus_yield_req_o; i++) @(negedge ref_clk_i);
    chk(bus_yield_req_o, 1'b1);
    for (int i = 0; i < 2000 && q < 12; i++) begin
      @(negedge ref_clk_i);
      q = (bus_yield_req_o || bus_valid_o) ? 0 : q + 1;
    end
    chk(prog_ready_o, 1'b1);
    chk(q, 12);
  endtask
  task automatic chk_log(input logic [2:0] ch, input logic rsrc, input int nrd, input int nwr);
    int rn, wn, last;
    logic rq;
    rn = 0;
    wn = 0;
    last = -1;
    foreach (l_wr[i]) if (l_wr[i] != rsrc) last = i;
    foreach (l_wr[i]) begin
      rq = (l_wr[i] != rsrc);
      if (l_wr[i]) wn++;
      else rn++;
      chk(l_ack[i], rq ? ch : ACK_IDLE);
      chk(l_eop[i], !(rq && i == last));
    end
    chk(rn, nrd);
    chk(wn, nwr);
    l_ack.delete();
    l_wr.delete();
    l_eop.delete();
  endtask
  task automatic chk_stat(input logic [2:0] ch, input logic [23:0] ra, ta, n, input logic tc, ar);
    @(negedge ref_clk_i);
    rd_ch_i = ch;
    @(negedge ref_clk_i);
    chk(rd_stat_o.req_addr, ra);
    chk(rd_stat_o.tgt_addr, ta);
    chk(rd_stat_o.count, n);
    chk(rd_stat_o.tc, tc);
    chk(rd_stat_o.armed, ar);
  endtask
  task automatic t_reset();
    chk(bus_yield_req_o, 1'b0);
    chk(bus_valid_o, 1'b0);
    chk(encoded_channel_ack_o, ACK_IDLE);
    chk(end_of_process_oe_n_o, 1'b1);
    channel_service_request_i[5] = 1'b1;
    repeat (6) @(negedge ref_clk_i);
    chk(bus_yield_req_o, 1'b0);
    chk(prog_ready_o, 1'b1);
    channel_service_request_i = 8'h00;
    $display("test reset done");
  endtask
  task automatic t_copy();
    grant_dly = 4'h3;
    wait_n = 4'h1;
    prog(3'h3, cf(24'h000010, 24'h000040, 24'h000003, 1'b0, 1'b0, 1'b0));
    sw(3);
    run_out();
    for (int k = 0; k < 4; k++) chk(host.mem[8'h40 - k], 8'(8'h10 + k) ^ 8'ha5);
    chk_log(3'h3, 1'b1, 4, 4);
    chk_stat(3'h3, 24'h000014, 24'h00003c, 24'hffffff, 1'b1, 1'b0);
    $display("test copy done");
  endtask
  task automatic t_unpack();
    grant_dly = 4'h0;
    wait_n = 4'h3;
    prog(3'h1, cf(24'h0000a0, 24'h000080, 24'h000002, 1'b1, 1'b0, 1'b1));
    channel_service_request_i[1] = 1'b1;
    run_out();
    channel_service_request_i = 8'h00;
    for (int k = 0; k < 3; k++) chk(host.mem[8'ha0 + k], 8'(8'h80 + k) ^ 8'ha5);
    chk(host.mem[8'ha3], 8'h06);
    chk_log(3'h1, 1'b0, 2, 3);
    chk_stat(3'h1, 24'h0000a3, 24'h000084, 24'hffffff, 1'b1, 1'b0);
    $display("test unpack done");
  endtask
  task automatic t_auto();
    grant_dly = 4'h1;
    wait_n = 4'h0;
    prog(3'h0, cf(24'h000020, 24'h000060, 24'h000001, 1'b0, 1'b1, 1'b0));
    sw(0);
    run_out();
    chk(host.mem[8'h60], 8'h85);
    chk_log(3'h0, 1'b1, 2, 2);
    chk_stat(3'h0, 24'h000020, 24'h000060, 24'h000001, 1'b1, 1'b1);
    $display("test autoinit done");
  endtask
  task automatic t_prio();
    grant_dly = 4'ha;
    n_rise = 0;
    prog(3'h6, cf(24'h000030, 24'h000078, 24'h000000, 1'b0, 1'b0, 1'b0));
    prog(3'h2, cf(24'h000032, 24'h00007a, 24'h000000, 1'b0, 1'b0, 1'b0));
    sw(6);
    sw(2);
    run_out();
    chk(l_ack[0], 3'h2);
    chk(n_rise, 2);
    chk(host.mem[8'h78], 8'h95);
    chk_stat(3'h6, 24'h000031, 24'h000077, 24'hffffff, 1'b1, 1'b0);
    l_ack.delete();
    l_wr.delete();
    l_eop.delete();
    $display("test priority done");
  endtask
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // whole run needs well under a thousand cycles
  initial begin
    #(6000 * 50);
    n_mismatch++;
    finish_test();
  end
  initial begin
    rst_n_i = 1'b0;
    prog_we_i = 1'b0;
    eop_pin_n = 1'b1;
    prog_ch_i = 3'h0;
    rd_ch_i = 3'h0;
    prog_cfg_i = '0;
    sw_req_i = 8'h00;
    channel_service_request_i = 8'h00;
    grant_dly = 4'h0;
    wait_n = 4'h0;
    prev_req = 1'b0;
    n_mismatch = 0;
    n_compared = 0;
    n_rise = 0;
    for (int i = 0; i < 256; i++) host.mem[i] = 8'(i) ^ 8'ha5;
    repeat (8) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    t_reset();
    t_copy();
    t_unpack();
    t_auto();
    t_prio();
    finish_test();
  end
endmodule
